// file: core/bmrs_top.sv
// Behaviour
// - link strap high selects link booting only with eprom strap 0 and select input 1; low selects EPROM, host or no booting
// - eprom strap 1, link strap 0: boot memory select driven as EPROM chip select
// - in multiprocessor systems only the bus master drives boot memory select
// - select input low with both straps 0 means no booting, run external memory
// - straps 0 0 with select input 1 selects host booting
// - straps 0 1 with select input 1 selects link port booting
// - select pin is driven only in EPROM mode; otherwise it stays an input
// - one instruction cycle per core clock period, no multiply or divide
// - reset gives a defined state, then execution starts at the reset vector
// - TMS steers the test state machine, TDI shifts in, TDO shifts out
// - scan logic runs from the core clock and steps on TCK edges, which pass through a two-stage synchroniser as an asynchronous input
`timescale 1ns/1ps
module bmrs_top #(
  parameter logic [bmrs_pkg::ADDR_W-1:0] RESET_VECTOR = bmrs_pkg::RESET_VECTOR
) (
  input  wire logic                          mclk,
  input  wire logic                          srst,
  input  wire logic                          eprom_boot_strap,
  input  wire logic                          link_boot_strap,
  input  wire logic                          boot_memory_select_i,
  output logic                               boot_memory_select_o,
  output logic                               boot_memory_select_oe,
  input  wire logic                          bus_master,
  input  wire logic                          eprom_select_req,
  input  wire bmrs_pkg::bmrs_jtag_t          jtag,
  output logic                               tdo,
  output bmrs_pkg::bmrs_mode_t               boot_mode,
  output logic                               strap_reserved,
  output logic                               core_run,
  output logic                               fetch_start,
  output logic [bmrs_pkg::ADDR_W-1:0]        fetch_addr,
  output logic [bmrs_pkg::CNT_W-1:0]         instr_count
);
  import bmrs_pkg::*;

  // ****************************************
  // strap decode
  // ****************************************
  function automatic bmrs_mode_t decode_mode(input bmrs_strap_t s);
    bmrs_mode_t m;
    m = BM_RSVD;
    if (s.eprom && !s.link) begin
      m = BM_EPROM;
    end else if (s.eprom && s.link) begin
      m = BM_RSVD;
    end else if (s.link) begin
      m = s.sel_pin ? BM_LINK : BM_RSVD;
    end else begin
      m = s.sel_pin ? BM_HOST : BM_NONE;
    end
    return m;
  endfunction : decode_mode

  // ****************************************
  // boot mode and reset entry
  // ****************************************
  bmrs_strap_t              boot_strap;
  bmrs_strap_t              next_boot_strap;
  logic                     pending;
  logic                     next_pending;
  bmrs_mode_t               next_boot_mode;
  logic                     next_strap_reserved;
  logic                     next_core_run;
  logic                     next_fetch_start;
  logic [ADDR_W-1:0]        next_fetch_addr;
  logic [CNT_W-1:0]         next_instr_count;
  logic                     next_sel_o;
  logic                     next_sel_oe;

  always_comb begin
    next_boot_strap     = boot_strap;
    next_pending        = 1'h0;
    next_boot_mode      = boot_mode;
    next_strap_reserved = strap_reserved;
    next_core_run       = core_run;
    next_fetch_start    = 1'h0;
    next_fetch_addr     = fetch_addr;
    next_instr_count    = instr_count;
    next_sel_o          = SELECT_IDLE;
    next_sel_oe         = 1'h0;
    if (srst) begin
      // straps followed every cycle of reset, last value kept
      next_boot_strap.eprom   = eprom_boot_strap;
      next_boot_strap.link    = link_boot_strap;
      next_boot_strap.sel_pin = boot_memory_select_i;
      next_pending        = 1'h1;
      next_boot_mode      = BM_NONE;
      next_strap_reserved = 1'h0;
      next_core_run       = 1'h0;
      next_fetch_addr     = RESET_VECTOR;
      next_instr_count    = '0;
    end else begin
      if (pending) begin
        next_boot_mode      = decode_mode(boot_strap);
        next_strap_reserved = (decode_mode(boot_strap) == BM_RSVD);
        next_core_run       = 1'h1;
        next_fetch_start    = 1'h1;
        next_fetch_addr     = RESET_VECTOR;
      end
      if (core_run) begin
        next_instr_count = instr_count + CNT_W'(1);
      end
      // pin driven only in EPROM mode and only while bus master
      next_sel_oe = (boot_mode == BM_EPROM) && bus_master;
      if ((boot_mode == BM_EPROM) && eprom_select_req && core_run) begin
        next_sel_o = SELECT_ACTIVE;
      end
    end
  end

  always_ff @(posedge mclk) begin
    boot_strap            <= next_boot_strap;
    pending               <= next_pending;
    boot_mode             <= next_boot_mode;
    strap_reserved        <= next_strap_reserved;
    core_run              <= next_core_run;
    fetch_start           <= next_fetch_start;
    fetch_addr            <= next_fetch_addr;
    instr_count           <= next_instr_count;
    boot_memory_select_o  <= next_sel_o;
    boot_memory_select_oe <= next_sel_oe;
  end

  // ****************************************
  // test clock synchroniser
  // ****************************************
  bmrs_jtag_t jsync1;
  bmrs_jtag_t jsync2;
  logic       tck_d;
  logic       tck_rise;
  logic       tck_fall;

  always_ff @(posedge mclk) begin
    if (srst) begin
      jsync1 <= JTAG_RESET;
      jsync2 <= JTAG_RESET;
      tck_d  <= JTAG_RESET.tck;
    end else begin
      jsync1 <= jtag;
      jsync2 <= jsync1;
      tck_d  <= jsync2.tck;
    end
  end

  always_comb begin
    tck_rise = jsync2.tck && !tck_d;
    tck_fall = !jsync2.tck && tck_d;
  end

  // ****************************************
  // test access port
  // ****************************************
  bmrs_tap_t             tap;
  bmrs_tap_t             next_tap;
  logic [IR_W-1:0]       ir;
  logic [IR_W-1:0]       next_ir;
  logic [IR_W-1:0]       ir_sh;
  logic [IR_W-1:0]       next_ir_sh;
  logic [BSR_W-1:0]      bsr;
  logic [BSR_W-1:0]      next_bsr;
  logic                  bypass;
  logic                  next_bypass;
  logic                  next_tdo;
  logic                  tms;

  always_comb begin
    tms         = jsync2.tms;
    next_tap    = tap;
    next_ir     = ir;
    next_ir_sh  = ir_sh;
    next_bsr    = bsr;
    next_bypass = bypass;
    next_tdo    = tdo;
    if (srst || !jsync2.trst_n) begin
      next_tap = TS_TLR;
      next_ir  = IR_BYPASS;
      next_tdo = 1'h0;
    end else if (tck_rise) begin
      case (tap)
        TS_TLR:    next_tap = tms ? TS_TLR : TS_RTI;
        TS_RTI:    next_tap = tms ? TS_SEL_DR : TS_RTI;
        TS_SEL_DR: next_tap = tms ? TS_SEL_IR : TS_CAP_DR;
        TS_CAP_DR: next_tap = tms ? TS_EX1_DR : TS_SH_DR;
        TS_SH_DR:  next_tap = tms ? TS_EX1_DR : TS_SH_DR;
        TS_EX1_DR: next_tap = tms ? TS_UP_DR : TS_PA_DR;
        TS_PA_DR:  next_tap = tms ? TS_EX2_DR : TS_PA_DR;
        TS_EX2_DR: next_tap = tms ? TS_UP_DR : TS_SH_DR;
        TS_UP_DR:  next_tap = tms ? TS_SEL_DR : TS_RTI;
        TS_SEL_IR: next_tap = tms ? TS_TLR : TS_CAP_IR;
        TS_CAP_IR: next_tap = tms ? TS_EX1_IR : TS_SH_IR;
        TS_SH_IR:  next_tap = tms ? TS_EX1_IR : TS_SH_IR;
        TS_EX1_IR: next_tap = tms ? TS_UP_IR : TS_PA_IR;
        TS_PA_IR:  next_tap = tms ? TS_EX2_IR : TS_PA_IR;
        TS_EX2_IR: next_tap = tms ? TS_UP_IR : TS_SH_IR;
        TS_UP_IR:  next_tap = tms ? TS_SEL_DR : TS_RTI;
        default:   next_tap = TS_TLR;
      endcase
      case (tap)
        TS_TLR: begin
          next_ir = IR_BYPASS;
        end
        TS_CAP_DR: begin
          // pin levels as seen by the core
          next_bsr    = {eprom_boot_strap, link_boot_strap, boot_memory_select_i,
                         boot_memory_select_o, boot_memory_select_oe};
          next_bypass = 1'h0;
        end
        TS_SH_DR: begin
          if (ir == IR_SAMPLE) begin
            next_bsr = {jsync2.tdi, bsr[BSR_W-1:1]};
          end else begin
            next_bypass = jsync2.tdi;
          end
        end
        TS_CAP_IR: begin
          next_ir_sh = IR_CAPTURE;
        end
        TS_SH_IR: begin
          next_ir_sh = {jsync2.tdi, ir_sh[IR_W-1:1]};
        end
        TS_UP_IR: begin
          next_ir = ir_sh;
        end
        default: begin
          next_ir = ir;
        end
      endcase
    end else if (tck_fall) begin
      // output changes on the falling test clock edge
      if (tap == TS_SH_DR) begin
        next_tdo = (ir == IR_SAMPLE) ? bsr[0] : bypass;
      end else if (tap == TS_SH_IR) begin
        next_tdo = ir_sh[0];
      end else begin
        next_tdo = 1'h0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    tap    <= next_tap;
    ir     <= next_ir;
    ir_sh  <= next_ir_sh;
    bsr    <= next_bsr;
    bypass <= next_bypass;
    tdo    <= next_tdo;
  end

endmodule : bmrs_top

// file: core/bmrs_pkg.sv
package bmrs_pkg;

  // ****************************************
  // widths and codes
  // ****************************************
  localparam int          IR_W          = 2;
  localparam int          BSR_W         = 5;
  localparam int          ADDR_W        = 24;
  localparam int          CNT_W         = 32;
  localparam logic [23:0] RESET_VECTOR  = 24'h00_0000;
  localparam logic [1:0]  IR_BYPASS     = 2'h3;
  localparam logic [1:0]  IR_SAMPLE     = 2'h1;
  localparam logic [1:0]  IR_CAPTURE    = 2'h1;
  localparam logic        SELECT_IDLE   = 1'h1;
  localparam logic        SELECT_ACTIVE = 1'h0;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic eprom;
    logic link;
    logic sel_pin;
  } bmrs_strap_t;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
  } bmrs_jtag_t;

  localparam bmrs_strap_t STRAP_RESET = 3'h0;
  // test pins rest at their idle high levels, test reset held, so no false edge follows reset
  localparam bmrs_jtag_t  JTAG_RESET  = 4'he;

  typedef enum logic [4:0] {
    BM_NONE  = 5'h01,
    BM_HOST  = 5'h02,
    BM_LINK  = 5'h04,
    BM_EPROM = 5'h08,
    BM_RSVD  = 5'h10
  } bmrs_mode_t;

  typedef enum logic [15:0] {
    TS_TLR    = 16'h0001,
    TS_RTI    = 16'h0002,
    TS_SEL_DR = 16'h0004,
    TS_CAP_DR = 16'h0008,
    TS_SH_DR  = 16'h0010,
    TS_EX1_DR = 16'h0020,
    TS_PA_DR  = 16'h0040,
    TS_EX2_DR = 16'h0080,
    TS_UP_DR  = 16'h0100,
    TS_SEL_IR = 16'h0200,
    TS_CAP_IR = 16'h0400,
    TS_SH_IR  = 16'h0800,
    TS_EX1_IR = 16'h1000,
    TS_PA_IR  = 16'h2000,
    TS_EX2_IR = 16'h4000,
    TS_UP_IR  = 16'h8000
  } bmrs_tap_t;

endpackage : bmrs_pkg

// file: verif/bmrs_chk.sv
`timescale 1ns/1ps
module bmrs_chk
  import bmrs_pkg::*;
#(
  parameter logic [ADDR_W-1:0] RESET_VECTOR = bmrs_pkg::RESET_VECTOR
) (
  input wire logic              mclk,
  input wire logic              srst,
  input wire logic              eprom_boot_strap,
  input wire logic              link_boot_strap,
  input wire logic              boot_memory_select_i,
  input wire logic              boot_memory_select_o,
  input wire logic              boot_memory_select_oe,
  input wire logic              bus_master,
  input wire logic              eprom_select_req,
  input wire bmrs_mode_t        boot_mode,
  input wire logic              strap_reserved,
  input wire logic              core_run,
  input wire logic              fetch_start,
  input wire logic [ADDR_W-1:0] fetch_addr,
  input wire logic [CNT_W-1:0]  instr_count
);
  // ****
  // strap decode and properties
  // ****
  logic seen;
  always_ff @(posedge mclk) seen <= 1'h1;
  function automatic bmrs_mode_t dec(input logic e, input logic l, input logic b);
    if (e) return l ? BM_RSVD : BM_EPROM;
    if (l) return b ? BM_LINK : BM_RSVD;
    return b ? BM_HOST : BM_NONE;
  endfunction : dec
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  a_mode_decode: assert property ($fell(srst) |=> boot_mode == dec($past(eprom_boot_strap, 2),
    $past(link_boot_strap, 2), $past(boot_memory_select_i, 2)) && strap_reserved == (boot_mode == BM_RSVD))
    else $error("boot mode differs from latched straps");
  a_mode_hold: assert property (!$past(srst) && !$past(srst, 2) |-> $stable(boot_mode) && $stable(strap_reserved))
    else $error("boot mode changed outside reset");
  a_oe_eprom: assert property (boot_memory_select_oe |-> boot_mode == BM_EPROM)
    else $error("select pin driven outside eprom mode");
  a_oe_master: assert property (boot_mode == BM_EPROM |=> boot_memory_select_oe == $past(bus_master))
    else $error("select enable does not follow bus mastership");
  a_select_follow: assert property (boot_memory_select_oe ##1 boot_memory_select_oe
    |-> boot_memory_select_o == !$past(eprom_select_req)) else $error("chip select does not follow request");
  a_fetch_pulse: assert property ($fell(srst) |=> fetch_start && core_run && fetch_addr == RESET_VECTOR
    ##1 !fetch_start) else $error("start of execution wrong");
  a_count_step: assert property (core_run && $past(core_run) |-> instr_count == $past(instr_count) + 32'h1)
    else $error("instruction count not one per clock");
  a_reset_state: assert property (@(posedge mclk) seen && $past(srst) |-> !core_run && !fetch_start
    && boot_memory_select_o && !boot_memory_select_oe) else $error("reset state wrong");
endmodule : bmrs_chk
bind bmrs_top bmrs_chk #(.RESET_VECTOR(RESET_VECTOR)) bmrs_chk_i (
  .mclk                  (mclk),
  .srst                  (srst),
  .eprom_boot_strap      (eprom_boot_strap),
  .link_boot_strap       (link_boot_strap),
  .boot_memory_select_i  (boot_memory_select_i),
  .boot_memory_select_o  (boot_memory_select_o),
  .boot_memory_select_oe (boot_memory_select_oe),
  .bus_master            (bus_master),
  .eprom_select_req      (eprom_select_req),
  .boot_mode             (boot_mode),
  .strap_reserved        (strap_reserved),
  .core_run              (core_run),
  .fetch_start           (fetch_start),
  .fetch_addr            (fetch_addr),
  .instr_count           (instr_count)
);

// file: verif/bmrs_board.sv
`timescale 1ns/1ps
module bmrs_board
  import bmrs_pkg::*;
(
  input wire logic        mclk,
  input wire logic        srst,
  input wire logic        allow_rsvd,
  input wire bmrs_strap_t want,
  input wire logic        sel_o,
  input wire logic        sel_oe,
  output bmrs_strap_t     strap,
  output logic            pin
);
  // ****
  // straps move only during reset; reserved ones only when commanded
  // ****
  always_ff @(posedge mclk) begin
    if (srst && (allow_rsvd || !(want.link && (want.eprom || !want.sel_pin)))) strap <= want;
  end
  // released pin settles at the strap level
  assign pin = sel_oe ? sel_o : strap.sel_pin;
endmodule : bmrs_board

// file: verif/bmrs_top_tb.sv
`timescale 1ns/1ps
module bmrs_top_tb;
  import bmrs_pkg::*;
  // ****
  // stimulus and checks
  // ****
  logic              mclk = 0, srst = 1, bus_master = 0, req = 0, rsvd = 0, prev_oe, pin, sel_o, sel_oe;
  logic              tdo, resv, run, fst;
  bmrs_strap_t       want = 3'h4, strap;
  bmrs_jtag_t        jtag = 4'he;
  bmrs_mode_t        mode;
  logic [ADDR_W-1:0] faddr;
  logic [CNT_W-1:0]  icnt, c0;
  logic [31:0]       tout;
  logic [1:0]        tbits;
  int                err_count = 0, checks_done = 0;
  always #4 mclk = ~mclk;
  bmrs_board bmrs_board_i (.mclk(mclk), .srst(srst), .allow_rsvd(rsvd), .want(want), .sel_o(sel_o),
    .sel_oe(sel_oe), .strap(strap), .pin(pin));
  bmrs_top bmrs_top_i (.mclk(mclk), .srst(srst), .eprom_boot_strap(strap.eprom), .link_boot_strap(strap.link),
    .boot_memory_select_i(pin), .boot_memory_select_o(sel_o), .boot_memory_select_oe(sel_oe),
    .bus_master(bus_master), .eprom_select_req(req), .jtag(jtag), .tdo(tdo), .boot_mode(mode),
    .strap_reserved(resv), .core_run(run), .fetch_start(fst), .fetch_addr(faddr), .instr_count(icnt));
  function automatic bmrs_mode_t exp_mode(input bmrs_strap_t s);
    if (s.eprom) return s.link ? BM_RSVD : BM_EPROM;
    if (s.link) return s.sel_pin ? BM_LINK : BM_RSVD;
    return s.sel_pin ? BM_HOST : BM_NONE;
  endfunction : exp_mode
  // pin levels captured by the scan path, eprom first down to the enable
  function automatic logic [4:0] exp_scan(input bmrs_strap_t s, input logic bm, input logic rq);
    logic oe, so;
    oe = bm && exp_mode(s) == BM_EPROM;
    so = !(rq && exp_mode(s) == BM_EPROM);
    return {s.eprom, s.link, oe ? so : s.sel_pin, so, oe};
  endfunction : exp_scan
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic boot(input bmrs_strap_t s, input int n);
    @(negedge mclk);
    srst = 1;
    want = s;
    rsvd = exp_mode(s) == BM_RSVD;
    bus_master = 0;
    req = 0;
    repeat (n) @(negedge mclk);
    srst = 0;
    @(negedge mclk);
    chk(fst, 1);
    chk(faddr, RESET_VECTOR);
    @(negedge mclk);
    chk(fst, 0);
    chk(mode, exp_mode(s));
    chk(resv, exp_mode(s) == BM_RSVD);
    c0 = icnt;
    prev_oe = sel_oe;
    repeat (20) begin
      bus_master = 1'($urandom);
      req = 1'($urandom);
      @(negedge mclk);
      chk(sel_oe, bus_master && exp_mode(s) == BM_EPROM);
      if (prev_oe && sel_oe) chk(sel_o, !req);
      chk(sel_o, !(req && exp_mode(s) == BM_EPROM));
      prev_oe = sel_oe;
    end
    chk(icnt, c0 + 32'd20);
  endtask : boot
  // test controller: one test clock per step, 4 core clocks low then 4 high, output taken before the rise
  task automatic jseq(input logic [31:0] ms, input logic [31:0] di, input int n, output logic [31:0] dout);
    dout = '0;
    for (int k = 0; k < n; k++) begin
      jtag.tms = ms[k];
      jtag.tdi = di[k];
      jtag.tck = 1'h0;
      repeat (4) @(negedge mclk);
      dout[k] = tdo;
      jtag.tck = 1'h1;
      repeat (4) @(negedge mclk);
    end
  endtask : jseq
  task automatic final_report;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report
  initial begin
    repeat (5000) @(posedge mclk);
    err_count++;
    final_report;
  end
  initial begin
    void'($urandom(32'h17309416));
    repeat (10) @(negedge mclk);
    jtag.trst_n = 1'h1;
    boot(3'h4, 10);
    for (int i = 0; i < 8; i++) boot(3'(i), 2);
    repeat (6) boot(3'($urandom), 2);
    // load the sample instruction, then capture and shift out the pin levels
    boot(3'h4, 2);
    jseq(32'h0003_02c6, 32'h0000_0020, 19, tout);
    chk(tout[7:5], 3'h1);
    chk(tout[16:12], exp_scan(want, bus_master, req));
    // a test reset pulse brings back the one-bit bypass path
    jtag.trst_n = 1'h0;
    repeat (4) @(negedge mclk);
    jtag.trst_n = 1'h1;
    repeat (4) @(negedge mclk);
    tbits = 2'($urandom);
    jseq(32'h0000_0062, {26'h0, tbits, 4'h0}, 8, tout);
    chk(tout[6:4], {1'h0, tbits[0], 1'h0});
    final_report;
  end
endmodule : bmrs_top_tb
